// [dtq_pkg.sv]
// Package for the port trigger qualifier: register map, field codes, status enums.
// Assumes one 32-bit AHB-Lite slave with word-aligned registers.
package dtq_pkg;
	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] DTQ_OFF_CTRL = 8'h00;
	localparam logic [7:0] DTQ_OFF_SEQ = 8'h04;
	localparam logic [7:0] DTQ_OFF_STATUS = 8'h08;
	localparam logic [7:0] DTQ_OFF_POS = 8'h0C;
	localparam logic [7:0] DTQ_OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] DTQ_OFF_IRQ_MASK = 8'h14;
	// ****************************************************************
	// Fields and reset values
	// ****************************************************************
	localparam int DTQ_SEL_LSB = 16;
	localparam logic [3:0] DTQ_STROBE_IDX_RST = 4'h0;
	localparam logic [3:0] DTQ_VALID_IDX_RST = 4'h1;
	localparam logic [10:0] DTQ_CACHE_DEPTH = 11'h400;
	localparam logic [9:0] DTQ_INSTR_MAX = 10'h3FF;
	localparam int DTQ_IRQ_W = 4;
	localparam int DTQ_IRQ_TRIG = 0;
	localparam int DTQ_IRQ_DONE = 1;
	localparam int DTQ_IRQ_CW = 2;
	localparam int DTQ_IRQ_TBLERR = 3;

	typedef enum logic [1:0] {DTQ_EDGE_NONE, DTQ_EDGE_RISE, DTQ_EDGE_FALL, DTQ_EDGE_BOTH}
		dtq_edge_e;
	typedef enum logic [1:0] {DTQ_POL_NONE, DTQ_POL_LOW, DTQ_POL_HIGH, DTQ_POL_BOTH} dtq_pol_e;
	typedef enum logic [1:0] {DTQ_ST_IDLE, DTQ_ST_RUN, DTQ_ST_WAIT, DTQ_ST_NOTREADY} dtq_seq_e;
	typedef enum logic [1:0] {DTQ_TBL_NONE, DTQ_TBL_OK, DTQ_TBL_ERR} dtq_tbl_e;

	typedef struct packed {
		logic [3:0] strobe_idx;
		dtq_edge_e strobe_edge;
		logic [3:0] valid_idx;
		dtq_pol_e valid_pol;
		logic rerun;
	} dtq_cfg_s;

	typedef struct packed {
		logic load_start;
		logic load_done;
		logic [10:0] load_size;
		logic start;
		logic instr_step;
		logic wait_instr;
		logic prog_end;
		logic tbl_ok;
		logic tbl_err;
	} dtq_seq_s;
endpackage

// [dtq_qualifier.sv]
// Trigger qualifier and sequencer status block for the digital I/O port.
// Assumes inputs synchronous to clk_i and an AHB-Lite master with single word transfers.
`timescale 1ns/10ps
module dtq_qualifier
	import dtq_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [7:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [31:0] digital_io_port_i,
	input wire dtq_seq_s seq_i,
	output logic trigger_o,
	output logic codeword_take_o,
	output logic seq_restart_o,
	output logic irq_o
);
	logic [31:0] rd_mux;
	logic ap_wr_reg;
	logic [7:0] ap_addr_reg;
	dtq_cfg_s cfg_reg;
	logic [DTQ_IRQ_W-1:0] irq_stat_reg;
	logic [DTQ_IRQ_W-1:0] irq_mask_reg;
	logic [DTQ_IRQ_W-1:0] irq_evt;
	logic [1:0] strobe_sync_reg;
	logic strobe_prev_reg;
	logic strobe_fire;
	logic valid_bit;
	logic valid_ok;
	dtq_seq_e seq_state_reg;
	dtq_tbl_e tbl_reg;
	logic loaded_reg;
	logic pending_reg;
	logic [9:0] pos_reg;
	logic [10:0] size_reg;
	logic [6:0] fill_pct;
	logic wr_go;

	function automatic logic pick_bit(input logic [31:0] bus, input logic [3:0] idx);
		pick_bit = bus[DTQ_SEL_LSB + int'(idx)];
	endfunction

	// ****************************************************************
	// AHB-Lite slave: zero wait states, always OKAY.
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			ap_wr_reg <= 1'b0;
			ap_addr_reg <= 8'h00;
		end
		else if (hready_i)
		begin
			ap_wr_reg <= hsel_i && htrans_i[1] && hwrite_i;
			ap_addr_reg <= haddr_i;
		end
	end

	assign wr_go = ap_wr_reg;

	always_ff @(posedge clk_i)
	begin
		hreadyout_o <= !sys_rst_i;
		hresp_o <= 1'b0;
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (haddr_i)
			DTQ_OFF_CTRL: rd_mux = {19'h0_0000, cfg_reg};
			DTQ_OFF_STATUS: rd_mux = {21'h00_0000, fill_pct, tbl_reg, seq_state_reg};
			DTQ_OFF_POS: rd_mux = {22'h00_0000, pos_reg};
			DTQ_OFF_IRQ_STAT: rd_mux = {28'h000_0000, irq_stat_reg};
			DTQ_OFF_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask_reg};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			hrdata_o <= 32'h0000_0000;
		else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i)
			hrdata_o <= rd_mux;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			cfg_reg <= '{DTQ_STROBE_IDX_RST, DTQ_EDGE_NONE, DTQ_VALID_IDX_RST, DTQ_POL_NONE, 1'b0};
		else if (wr_go && ap_addr_reg == DTQ_OFF_CTRL)
			cfg_reg <= hwdata_i[12:0];
	end

	// ****************************************************************
	// Strobe edge detection and valid qualification.
	// ****************************************************************
	// The first stage is read only by the second; edges compare stage two with the prior sample.
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			strobe_sync_reg <= 2'b00;
			strobe_prev_reg <= 1'b0;
		end
		else
		begin
			strobe_sync_reg <= {strobe_sync_reg[0], pick_bit(digital_io_port_i, cfg_reg.strobe_idx)};
			strobe_prev_reg <= strobe_sync_reg[1];
		end
	end

	always_comb
	begin
		case (cfg_reg.strobe_edge)
			DTQ_EDGE_RISE: strobe_fire = strobe_sync_reg[1] && !strobe_prev_reg;
			DTQ_EDGE_FALL: strobe_fire = !strobe_sync_reg[1] && strobe_prev_reg;
			DTQ_EDGE_BOTH: strobe_fire = strobe_sync_reg[1] != strobe_prev_reg;
			default: strobe_fire = 1'b0;
		endcase
	end

	assign valid_bit = pick_bit(digital_io_port_i, cfg_reg.valid_idx);

	// Polarities "none" and "both" ignore the bit, so every codeword is taken; low and high rely on it.
	always_comb
	begin
		case (cfg_reg.valid_pol)
			DTQ_POL_LOW: valid_ok = !valid_bit;
			DTQ_POL_HIGH: valid_ok = valid_bit;
			default: valid_ok = 1'b1;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			trigger_o <= 1'b0;
			codeword_take_o <= 1'b0;
		end
		else
		begin
			trigger_o <= strobe_fire && seq_state_reg == DTQ_ST_WAIT;
			codeword_take_o <= valid_ok;
		end
	end

	// ****************************************************************
	// Sequencer status tracking.
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			loaded_reg <= 1'b0;
			pending_reg <= 1'b0;
			size_reg <= 11'h000;
		end
		else if (seq_i.load_start)
		begin
			pending_reg <= 1'b1;
			loaded_reg <= 1'b0;
		end
		else if (seq_i.load_done)
		begin
			pending_reg <= 1'b0;
			loaded_reg <= 1'b1;
			size_reg <= (seq_i.load_size > DTQ_CACHE_DEPTH) ? DTQ_CACHE_DEPTH : seq_i.load_size;
		end
	end

	// Fill percent; sizes are capped at the cache depth so the result stays within 0..100.
	assign fill_pct = 7'((18'(size_reg) * 18'd100) / 18'(DTQ_CACHE_DEPTH));

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			seq_state_reg <= DTQ_ST_NOTREADY;
			seq_restart_o <= 1'b0;
		end
		else
		begin
			seq_restart_o <= 1'b0;
			if (seq_i.load_start || !(loaded_reg || seq_i.load_done) || pending_reg && !seq_i.load_done)
				seq_state_reg <= DTQ_ST_NOTREADY;
			else
				case (seq_state_reg)
					DTQ_ST_NOTREADY: seq_state_reg <= DTQ_ST_IDLE;
					DTQ_ST_IDLE: if (seq_i.start) seq_state_reg <= DTQ_ST_RUN;
					DTQ_ST_RUN:
						if (seq_i.prog_end)
						begin
							seq_state_reg <= cfg_reg.rerun ? DTQ_ST_RUN : DTQ_ST_IDLE;
							seq_restart_o <= cfg_reg.rerun;
						end
						else if (seq_i.wait_instr)
							seq_state_reg <= DTQ_ST_WAIT;
					DTQ_ST_WAIT: if (strobe_fire) seq_state_reg <= DTQ_ST_RUN;
					default: seq_state_reg <= DTQ_ST_NOTREADY;
				endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || seq_state_reg == DTQ_ST_IDLE || seq_state_reg == DTQ_ST_NOTREADY)
			pos_reg <= 10'h000;
		else if (seq_state_reg == DTQ_ST_RUN && seq_i.prog_end)
			pos_reg <= 10'h000;
		else if (seq_state_reg == DTQ_ST_RUN && seq_i.instr_step && pos_reg != DTQ_INSTR_MAX)
			pos_reg <= pos_reg + 10'h001;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || seq_i.load_start)
			tbl_reg <= DTQ_TBL_NONE;
		else if (seq_i.tbl_err)
			tbl_reg <= DTQ_TBL_ERR;
		else if (seq_i.tbl_ok)
			tbl_reg <= DTQ_TBL_OK;
	end

	// ****************************************************************
	// Interrupts: sticky status, write one to clear, set wins.
	// ****************************************************************
	assign irq_evt = {seq_i.tbl_err, codeword_take_o && cfg_reg.valid_pol != DTQ_POL_NONE,
		seq_state_reg == DTQ_ST_RUN && seq_i.prog_end, strobe_fire};

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
			irq_o <= 1'b0;
		end
		else
		begin
			irq_stat_reg <= (irq_stat_reg & ~((wr_go && ap_addr_reg == DTQ_OFF_IRQ_STAT) ?
				hwdata_i[DTQ_IRQ_W-1:0] : '0)) | irq_evt;
			if (wr_go && ap_addr_reg == DTQ_OFF_IRQ_MASK)
				irq_mask_reg <= hwdata_i[DTQ_IRQ_W-1:0];
			irq_o <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	sequence s_rise;
		strobe_sync_reg[1] && !strobe_prev_reg;
	endsequence
	sequence s_waiting;
		seq_state_reg == DTQ_ST_WAIT;
	endsequence

	property p_rise_trig;
		@(posedge clk_i) disable iff (sys_rst_i)
		(cfg_reg.strobe_edge == DTQ_EDGE_RISE) and s_rise and s_waiting |=> trigger_o;
	endproperty
	a_rise_trig: assert property (p_rise_trig) else $error("rise edge missed");
	property p_none_quiet;
		@(posedge clk_i) disable iff (sys_rst_i)
		cfg_reg.strobe_edge == DTQ_EDGE_NONE |=> !trigger_o;
	endproperty
	a_none_quiet: assert property (p_none_quiet) else $error("trigger while disabled");
	property p_sync;
		@(posedge clk_i) disable iff (sys_rst_i)
		cfg_reg.strobe_edge == DTQ_EDGE_BOTH |-> strobe_fire == $changed(strobe_sync_reg[1]);
	endproperty
	a_sync: assert property (p_sync) else $error("strobe history wrong");
	property p_pol_high;
		@(posedge clk_i) disable iff (sys_rst_i)
		cfg_reg.valid_pol == DTQ_POL_HIGH && !valid_bit |=> !codeword_take_o;
	endproperty
	a_pol_high: assert property (p_pol_high) else $error("low valid accepted");
	property p_notready;
		@(posedge clk_i) disable iff (sys_rst_i)
		seq_i.load_start |=> seq_state_reg == DTQ_ST_NOTREADY;
	endproperty
	a_notready: assert property (p_notready) else $error("ready during load");
	property p_wait_release;
		@(posedge clk_i) disable iff (sys_rst_i)
		s_waiting ##1 (s_waiting and !strobe_fire and loaded_reg and !seq_i.load_start) |=> s_waiting;
	endproperty
	a_wait_release: assert property (p_wait_release) else $error("left wait untriggered");
	property p_fill;
		@(posedge clk_i) disable iff (sys_rst_i)
		fill_pct <= 7'd100;
	endproperty
	a_fill: assert property (p_fill) else $error("fill above 100");
	property p_rerun;
		@(posedge clk_i) disable iff (sys_rst_i)
		seq_state_reg == DTQ_ST_RUN && seq_i.prog_end && cfg_reg.rerun && loaded_reg
			&& !seq_i.load_start && !pending_reg |=> seq_restart_o && seq_state_reg == DTQ_ST_RUN;
	endproperty
	a_rerun: assert property (p_rerun) else $error("rerun not issued");
	property p_tbl;
		@(posedge clk_i) disable iff (sys_rst_i)
		seq_i.tbl_err && !seq_i.load_start |=> tbl_reg == DTQ_TBL_ERR;
	endproperty
	a_tbl: assert property (p_tbl) else $error("table error lost");
	property p_pos;
		@(posedge clk_i) disable iff (sys_rst_i)
		seq_state_reg == DTQ_ST_IDLE |=> pos_reg == 10'h000;
	endproperty
	a_pos: assert property (p_pos) else $error("position not cleared");
endmodule

// [dtq_port_partner.sv]
// External digital controller model that drives codewords, strobe and valid onto the port.
// Assumes the bench sets its inputs by non-blocking assignment just after a rising edge.
`timescale 1ns/10ps
module dtq_port_partner
(
	input wire logic clk_i,
	input wire logic send_i,
	input wire logic [15:0] codeword_i,
	input wire logic valid_lvl_i,
	input wire logic strobe_i,
	input wire logic [3:0] strobe_idx_i,
	input wire logic [3:0] valid_idx_i,
	output logic [31:0] port_o
);
	logic [15:0] idle_pat_reg = 16'hA5A5;

	// Lines without a codeword change every cycle and the valid line carries the inverse level, so a stale value never looks valid under low or high polarity.
	always_ff @(posedge clk_i)
		idle_pat_reg <= ~idle_pat_reg;

	always_comb
	begin
		port_o = '0;
		port_o[15:0] = send_i ? codeword_i : idle_pat_reg;
		port_o[16 + strobe_idx_i] = strobe_i;
		port_o[16 + valid_idx_i] = send_i ? valid_lvl_i : !valid_lvl_i;
	end
endmodule

// [dtq_qualifier_tb.sv]
// Self-checking bench for the port trigger qualifier: AHB-Lite tasks and sequencer pulses.
// Assumes one 20 MHz clock and the register map and field layout of the package.
`timescale 1ns/10ps
module dtq_qualifier_tb
	import dtq_pkg::*;
;
	localparam logic [18:0] LSTART = 19'h4_0000;
	localparam logic [18:0] LDONE = 19'h2_0000;
	localparam logic [18:0] START = 19'h0_0020;
	localparam logic [18:0] STEP = 19'h0_0010;
	localparam logic [18:0] WAITI = 19'h0_0008;
	localparam logic [18:0] PEND = 19'h0_0004;
	localparam logic [18:0] TOK = 19'h0_0002;
	localparam logic [18:0] TERR = 19'h0_0001;
	logic clk_i = 1'b0;
	logic rst = 1'b1;
	logic hsel, hwrite, hready, hresp, trig, take, restart, irq;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, port, rd;
	dtq_seq_s seq;
	logic send, vlvl, strobe;
	logic [15:0] cw;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	int trig_cnt = 0;
	int rst_cnt = 0;
	int n;

	dtq_qualifier dut_u (.clk_i(clk_i), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.digital_io_port_i(port), .seq_i(seq), .trigger_o(trig), .codeword_take_o(take),
		.seq_restart_o(restart), .irq_o(irq));
	dtq_port_partner partner_u (.clk_i(clk_i), .send_i(send), .codeword_i(cw),
		.valid_lvl_i(vlvl), .strobe_i(strobe), .strobe_idx_i(4'd5), .valid_idx_i(4'd9),
		.port_o(port));

	initial
		forever #25 clk_i = ~clk_i;

	// The ceiling is about twenty times the length of the whole sequence below.
	always @(posedge clk_i)
	begin
		cycles++;
		if (trig === 1'b1)
			trig_cnt++;
		if (restart === 1'b1)
			rst_cnt++;
		if (cycles == 6000)
		begin
			mismatches++;
			report_and_stop();
		end
	end

	task report_and_stop;
		$display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One single word transfer; read data is taken at the edge that ends the data phase.
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge clk_i); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		check(what, exp, rd);
		check("hresp", 32'h0000_0000, {31'h0, hresp});
	endtask

	task sq(input logic [18:0] v);
		@(posedge clk_i);
		seq <= dtq_seq_s'(v);
		@(posedge clk_i);
		seq <= '0;
	endtask

	task tick(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	function automatic logic [31:0] ctrl(input logic [1:0] e, input logic [1:0] p,
		input logic r);
		return {19'h0_0000, 4'd5, e, 4'd9, p, r};
	endfunction

	initial
	begin
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		seq = '0;
		send = 1'b1;
		cw = 16'h1234;
		vlvl = 1'b0;
		strobe = 1'b0;
		repeat (8) @(posedge clk_i);
		rst <= 1'b0;
		tick(2);
		rdc("ctrl reset", DTQ_OFF_CTRL, 32'h0000_0008);
		rdc("status reset", DTQ_OFF_STATUS, 32'h0000_0003);
		bus(1'b1, 8'h40, 32'hFFFF_FFFF);
		rdc("unmapped", 8'h40, 32'h0000_0000);
		rdc("reserved", DTQ_OFF_SEQ, 32'h0000_0000);
		sq(LSTART);
		rdc("pending load", DTQ_OFF_STATUS, 32'h0000_0003);
		sq(LDONE | 19'h0_8000);
		tick(3);
		rdc("loaded", DTQ_OFF_STATUS, 32'h0000_0320);
		sq(START);
		sq(STEP);
		sq(STEP);
		sq(STEP);
		tick(2);
		rdc("position", DTQ_OFF_POS, 32'h0000_0003);
		rdc("running", DTQ_OFF_STATUS, 32'h0000_0321);
		$display("Test reset and load done");
		for (int m = 0; m < 4; m++)
		begin
			n = trig_cnt;
			bus(1'b1, DTQ_OFF_CTRL, ctrl(2'(m), 2'd0, 1'b0));
			sq(WAITI);
			strobe <= 1'b1;
			tick(8);
			sq(WAITI);
			strobe <= 1'b0;
			tick(8);
			check("trigger count", 32'(m % 2 + m / 2), 32'(trig_cnt - n));
		end
		bus(1'b1, DTQ_OFF_CTRL, ctrl(DTQ_EDGE_NONE, 2'd0, 1'b0));
		sq(WAITI);
		rdc("waiting", DTQ_OFF_STATUS, 32'h0000_0322);
		bus(1'b1, DTQ_OFF_CTRL, ctrl(DTQ_EDGE_RISE, 2'd0, 1'b0));
		strobe <= 1'b1;
		tick(8);
		rdc("released", DTQ_OFF_STATUS, 32'h0000_0321);
		$display("Test strobe edges done");
		bus(1'b0, DTQ_OFF_IRQ_STAT, 32'h0000_0000);
		check("edge flag", 32'h0000_0001, rd & 32'h0000_0001);
		bus(1'b1, DTQ_OFF_IRQ_MASK, 32'h0000_0001);
		tick(2);
		check("irq raised", 32'h0000_0001, {31'h0, irq});
		bus(1'b1, DTQ_OFF_IRQ_STAT, 32'h0000_0001);
		tick(2);
		check("irq cleared", 32'h0000_0000, {31'h0, irq});
		bus(1'b1, DTQ_OFF_IRQ_MASK, 32'h0000_0000);
		$display("Test interrupt done");
		bus(1'b1, DTQ_OFF_CTRL, ctrl(DTQ_EDGE_RISE, 2'd0, 1'b1));
		n = rst_cnt;
		sq(PEND);
		tick(3);
		check("restart pulse", 32'h0000_0001, 32'(rst_cnt - n));
		rdc("rerun running", DTQ_OFF_STATUS, 32'h0000_0321);
		bus(1'b1, DTQ_OFF_CTRL, ctrl(DTQ_EDGE_RISE, 2'd0, 1'b0));
		sq(PEND);
		tick(3);
		check("no restart", 32'h0000_0001, 32'(rst_cnt - n));
		rdc("idle", DTQ_OFF_STATUS, 32'h0000_0320);
		rdc("position idle", DTQ_OFF_POS, 32'h0000_0000);
		bus(1'b0, DTQ_OFF_IRQ_STAT, 32'h0000_0000);
		check("end flag", 32'h0000_0002, rd & 32'h0000_0002);
		$display("Test rerun done");
		for (int p = 0; p < 4; p++)
			for (int v = 0; v < 2; v++)
			begin
				bus(1'b1, DTQ_OFF_CTRL, ctrl(DTQ_EDGE_RISE, 2'(p), 1'b0));
				vlvl <= v[0];
				tick(3);
				check("codeword take", (p == 0 || p == 3) ? 32'h1 : 32'((p == 1) ^ v[0]),
					{31'h0, take});
			end
		bus(1'b0, DTQ_OFF_IRQ_STAT, 32'h0000_0000);
		check("codeword flag", 32'h0000_0004, rd & 32'h0000_0004);
		$display("Test valid polarity done");
		sq(TERR);
		tick(2);
		rdc("table error", DTQ_OFF_STATUS, 32'h0000_0328);
		bus(1'b0, DTQ_OFF_IRQ_STAT, 32'h0000_0000);
		check("table flag", 32'h0000_0008, rd & 32'h0000_0008);
		sq(TOK);
		tick(2);
		rdc("table ok", DTQ_OFF_STATUS, 32'h0000_0324);
		sq(LSTART);
		tick(2);
		bus(1'b0, DTQ_OFF_STATUS, 32'h0000_0000);
		check("reload pending", 32'h0000_0003, rd & 32'h0000_0003);
		sq(LDONE | 19'h1_0000);
		tick(3);
		rdc("full cache", DTQ_OFF_STATUS, 32'h0000_0640);
		$display("Test table and cache done");
		report_and_stop();
	end
endmodule
